/* tois_consts.vh */
// Purpose: Constants for the timer output idle-level block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`ifndef TOIS_CONSTS_VH
`define TOIS_CONSTS_VH
`define TOIS_ADDR_W          4
`define TOIS_OFF_CTRL2       4'h0
`define TOIS_OFF_LOCK        4'h4
`define TOIS_OFF_OUTEN       4'h8
`define TOIS_OFF_STATUS      4'hC
`define TOIS_BIT_CH1_MAIN    8
`define TOIS_BIT_CH1_COMP    9
`define TOIS_BIT_CH2_MAIN    10
`define TOIS_BIT_CH2_COMP    11
`define TOIS_BIT_CH3_MAIN    12
`define TOIS_BIT_CH3_COMP    13
`define TOIS_BIT_CH4_MAIN    14
`define TOIS_IDLE_MASK       16'h7F00
`define TOIS_CTRL2_RST       16'h0000
`define TOIS_LOCK_W          2
`define TOIS_LOCK_RST        2'h0
`define TOIS_RESP_OKAY       2'h0
`define TOIS_RESP_SLVERR     2'h2
`define TOIS_DT_RST          8'h00
`endif

/* tois_out_stage.v */
// Purpose: One output channel: dead time then idle level when disabled
// Assumes: Single clock, sync active-high reset
// Notes:   Dead time counted in clock cycles after enable falls
`timescale 1ns/1ps
`default_nettype none
module tois_out_stage #(
    parameter DT_W = 8
) (
    input  wire            clock,
    input  wire            srst,
    input  wire            main_output_enable,
    input  wire            run_level,
    input  wire            idle_level,
    input  wire [DT_W-1:0] dead_cycles,
    output reg             pin_q,
    output reg             idle_q
);
    reg [DT_W-1:0] cnt_q;
    reg            en_q;

    always @(posedge clock) begin
        if (srst) begin
            cnt_q  <= {DT_W{1'b0}};
            en_q   <= 1'b0;
            pin_q  <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            en_q <= main_output_enable;
            if (main_output_enable) begin
                pin_q  <= run_level;
                idle_q <= 1'b0;
                cnt_q  <= {DT_W{1'b0}};
            end else if (en_q && dead_cycles != {DT_W{1'b0}}) begin
                // Both switches off during dead time
                pin_q <= 1'b0;
                cnt_q <= dead_cycles;
            end else if (cnt_q > {{(DT_W-1){1'b0}}, 1'b1}) begin
                pin_q <= 1'b0;
                cnt_q <= cnt_q - {{(DT_W-1){1'b0}}, 1'b1};
            end else begin
                pin_q  <= idle_level;
                idle_q <= 1'b1;
                cnt_q  <= {DT_W{1'b0}};
            end
        end
    end
endmodule // tois_out_stage
`default_nettype wire

/* tois_top.v */
// What this block does
// - Disabled: ch4 main takes bit 14 after dead time
// - Disabled: ch3 complementary takes bit 13 after dead time
// - Lock level 1-3 blocks idle-level writes
// - Bits 12,10: ch3/ch2 main idle; reset zero
// - Bits 11,9: ch2/ch1 comp idle; reset zero
// - Bit 8: ch1 main idle; reset zero
//
// Purpose: Idle-level selection for seven timer output pins
// Assumes: AXI4-Lite slave, 100 MHz clock, sync reset
// Notes:   Pin order ch1m,ch1c,ch2m,ch2c,ch3m,ch3c,ch4m
`timescale 1ns/1ps
`default_nettype none
`include "tois_consts.vh"
module tois_top #(
    parameter NCH  = 7,
    parameter DT_W = 8
) (
    input  wire                    clock,
    input  wire                    srst,
    input  wire [`TOIS_ADDR_W-1:0] s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`TOIS_ADDR_W-1:0] s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    input  wire [NCH-1:0]          run_levels,
    output wire [NCH-1:0]          out_pins
);
    reg  [15:0]             ctrl2_q;
    reg  [`TOIS_LOCK_W-1:0] lock_q;
    reg                     moe_q;
    reg  [DT_W-1:0]         dead_q;
    reg  [`TOIS_ADDR_W-1:0] aw_q;
    reg  [31:0]             wd_q;
    reg  [3:0]              ws_q;
    reg                     aw_ok_q;
    reg                     w_ok_q;
    wire [NCH-1:0]          idle_st;
    wire [NCH-1:0]          idle_lv;
    wire                    do_wr;
    wire [15:0]             wmask;
    wire                    locked;
    wire                    aw_hs;
    wire                    w_hs;
    wire                    b_hs;
    wire                    ar_hs;
    wire                    r_hs;
    reg  [15:0]             ctrl2_d;
    reg  [`TOIS_LOCK_W-1:0] lock_d;
    reg                     moe_d;
    reg  [DT_W-1:0]         dead_d;
    reg  [1:0]              bresp_d;
    reg  [31:0]             rdata_d;
    reg  [1:0]              rresp_d;

    assign do_wr  = aw_ok_q && w_ok_q && !s_axi_bvalid;
    assign locked = (lock_q != `TOIS_LOCK_RST);
    assign wmask  = {{8{ws_q[1]}}, {8{ws_q[0]}}};
    assign idle_lv = ctrl2_q[`TOIS_BIT_CH4_MAIN:`TOIS_BIT_CH1_MAIN];
    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign b_hs    = s_axi_bvalid && s_axi_bready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    assign r_hs    = s_axi_rvalid && s_axi_rready;

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            tois_out_stage #(
                .DT_W (DT_W)
            ) u_stage (
                .clock              (clock),
                .srst               (srst),
                .main_output_enable (moe_q),
                .run_level          (run_levels[gi]),
                .idle_level         (idle_lv[gi]),
                .dead_cycles        (dead_q),
                .pin_q              (out_pins[gi]),
                .idle_q             (idle_st[gi])
            );
        end
    endgenerate

    // Next register values for the pending write; lock gates idle bits
    always @* begin
        ctrl2_d = ctrl2_q;
        lock_d  = lock_q;
        moe_d   = moe_q;
        dead_d  = dead_q;
        bresp_d = `TOIS_RESP_OKAY;
        case (aw_q)
            `TOIS_OFF_CTRL2: begin
                // Lock freezes the idle-level field here and the dead time at OUTEN
                if (!locked) begin
                    ctrl2_d = (ctrl2_q & ~(wmask & `TOIS_IDLE_MASK))
                            | (wd_q[15:0] & wmask & `TOIS_IDLE_MASK);
                end
            end
            `TOIS_OFF_LOCK: begin
                // Write-once level, so software cannot unlock
                if (ws_q[0] && !locked) begin
                    lock_d = wd_q[`TOIS_LOCK_W-1:0];
                end
            end
            `TOIS_OFF_OUTEN: begin
                if (ws_q[0]) begin
                    moe_d = wd_q[0];
                end
                if (ws_q[1] && !locked) begin
                    dead_d = wd_q[15:8];
                end
            end
            `TOIS_OFF_STATUS: begin
                // Read-only; write accepted and dropped
                bresp_d = `TOIS_RESP_OKAY;
            end
            default: begin
                bresp_d = `TOIS_RESP_SLVERR;
            end
        endcase
    end

    // Read data follows the live address; registered on capture
    always @* begin
        rdata_d = 32'h0000_0000;
        rresp_d = `TOIS_RESP_OKAY;
        case (s_axi_araddr)
            `TOIS_OFF_CTRL2: begin
                rdata_d = {16'h0000, ctrl2_q};
            end
            `TOIS_OFF_LOCK: begin
                rdata_d = {{(32-`TOIS_LOCK_W){1'b0}}, lock_q};
            end
            `TOIS_OFF_OUTEN: begin
                rdata_d = {16'h0000, dead_q, 7'h00, moe_q};
            end
            `TOIS_OFF_STATUS: begin
                rdata_d = {16'h0000, 1'b0, idle_st, 1'b0, out_pins};
            end
            default: begin
                rresp_d = `TOIS_RESP_SLVERR;
            end
        endcase
    end

    // Write channel: capture address and data in either order
    always @(posedge clock) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TOIS_RESP_OKAY;
            aw_ok_q       <= 1'b0;
            w_ok_q        <= 1'b0;
            aw_q          <= {`TOIS_ADDR_W{1'b0}};
            wd_q          <= 32'h0000_0000;
            ws_q          <= 4'h0;
            ctrl2_q       <= `TOIS_CTRL2_RST;
            lock_q        <= `TOIS_LOCK_RST;
            moe_q         <= 1'b0;
            dead_q        <= `TOIS_DT_RST;
        end else begin
            if (aw_hs) begin
                aw_q          <= s_axi_awaddr;
                aw_ok_q       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                w_ok_q       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= bresp_d;
                ctrl2_q      <= ctrl2_d;
                lock_q       <= lock_d;
                moe_q        <= moe_d;
                dead_q       <= dead_d;
            end
            if (b_hs) begin
                s_axi_bvalid  <= 1'b0;
                aw_ok_q       <= 1'b0;
                w_ok_q        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after address
    always @(posedge clock) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TOIS_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= rresp_d;
                s_axi_rdata   <= rdata_d;
            end
            if (r_hs) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // tois_top
`default_nettype wire

/* tois_top_asserts.sv */
// Purpose: Port-level checks for tois_top
// Assumes: Bench offers write address and data together
// Notes:   Design lags the shadows, so checks wait dead time plus margin
`timescale 1ns/1ps
`default_nettype none
`include "tois_consts.vh"
module tois_top_asserts #(
    parameter NCH = 7
) (
    input wire logic           clock,
    input wire logic           srst,
    input wire logic [3:0]     s_axi_awaddr,
    input wire logic           s_axi_awvalid,
    input wire logic           s_axi_awready,
    input wire logic [31:0]    s_axi_wdata,
    input wire logic           s_axi_wvalid,
    input wire logic           s_axi_wready,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic           s_axi_rvalid,
    input wire logic [NCH-1:0] run_levels,
    input wire logic [NCH-1:0] out_pins
);
    logic [6:0] idle_q;
    logic [7:0] dead_q;
    logic       en_q, lk_q;
    logic [9:0] cnt_q;
    wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ok = cnt_q > {2'h0, dead_q} + 10'h004;
    always_ff @(posedge clock) begin
        if (srst) begin
            {idle_q, dead_q, en_q, lk_q, cnt_q} <= '0;
        end else begin
            // Any write restarts settling, so a shadow ahead of the design never misfires
            cnt_q <= wr ? 10'h000 : cnt_q + {9'h000, cnt_q != 10'h3FF};
            if (wr && !lk_q && s_axi_awaddr == `TOIS_OFF_CTRL2)
                idle_q <= s_axi_wdata[14:8];
            if (wr && !lk_q && s_axi_awaddr == `TOIS_OFF_LOCK)
                lk_q <= |s_axi_wdata[1:0];
            if (wr && s_axi_awaddr == `TOIS_OFF_OUTEN) begin
                en_q <= s_axi_wdata[0];
                if (!lk_q) dead_q <= s_axi_wdata[15:8];
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence wr_taken; wr; endsequence
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    ch4_idle_a:
        assert property (!en_q && ok |-> out_pins[6] == idle_q[6])
        else $error("ch4 main idle level wrong");
    ch3c_idle_a:
        assert property (!en_q && ok |-> out_pins[5] == idle_q[5])
        else $error("ch3 comp idle level wrong");
    main_idle_a: assert property (!en_q && ok |->
        {out_pins[4], out_pins[2]} == {idle_q[4], idle_q[2]})
        else $error("ch3 or ch2 main idle level wrong");
    comp_idle_a: assert property (!en_q && ok |->
        {out_pins[3], out_pins[1]} == {idle_q[3], idle_q[1]})
        else $error("ch2 or ch1 comp idle level wrong");
    ch1_idle_a:
        assert property (!en_q && ok |-> out_pins[0] == idle_q[0])
        else $error("ch1 main idle level wrong");
    lock_freeze_a:
        assert property (lk_q && !en_q && ok |-> out_pins == idle_q)
        else $error("idle levels changed under lock");
    run_follow_a:
        assert property (en_q && ok |-> out_pins == $past(run_levels))
        else $error("enabled pins not following run levels");
endmodule // tois_top_asserts
bind tois_top tois_top_asserts #(.NCH(NCH)) chk_i (.clock, .srst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .run_levels, .out_pins);
`default_nettype wire

/* tois_gate_drv.sv */
// Purpose: Gate driver model latching the pin levels
// Assumes: Driver samples on the timer clock
// Notes:   One cycle of driver delay
`timescale 1ns/1ps
`default_nettype none
module tois_gate_drv #(
    parameter NCH = 7
) (
    input  wire logic           clock,
    input  wire logic [NCH-1:0] gate_in,
    output var  logic [NCH-1:0] gate_q
);
    always_ff @(posedge clock) gate_q <= gate_in;
endmodule // tois_gate_drv
`default_nettype wire

/* tois_top_tb.sv */
// Purpose: Self-checking bench for tois_top
// Assumes: Full write strobes; bus master waits on handshakes
// Notes:   Run levels come from an LFSR seeded with 6060
`timescale 1ns/1ps
`default_nettype none
`include "tois_consts.vh"
module tois_top_tb;
    logic        clock = 1'b0, srst = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0000_0000, ctrl_m, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic [6:0]  run_levels = 7'h00;
    logic [15:0] lf_q = 16'h17AC;
    logic [1:0]  rs;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [6:0]  out_pins, gate_q;
    int          fail_count = 0, tests_run = 0, cyc = 0, i, lvl;
    always #5 clock = ~clock;
    tois_top uut (.clock, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_levels, .out_pins);
    tois_gate_drv drv (.clock, .gate_in(out_pins), .gate_q);
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge clock) begin
        lf_q <= lfsr_next(lf_q);
        run_levels <= lf_q[6:0];
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One edge first, so a handshake signal is never set twice in a step
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        while (!done) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) begin
                rd = s_axi_rdata;
                rs = w ? s_axi_bresp : s_axi_rresp;
                {s_axi_bready, s_axi_rready} <= 2'h0;
                done = 1'b1;
            end
        end
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        ctrl_m = 32'h0000_0000;
    endtask
    task automatic idle_chk();
        repeat (12) @(posedge clock);
        chk("idle", 32'(gate_q), ctrl_m >> 8);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        do_reset();
        bus(1'b0, `TOIS_OFF_CTRL2, 32'h0000_0000);
        chk("ctrl2_reset", rd, 32'h0000_0000);
        bus(1'b1, `TOIS_OFF_OUTEN, 32'h0000_0300);
        for (i = 0; i < 10; i++) begin
            ctrl_m = i < 7 ? 32'h0000_0100 << i : {17'h0, lf_q[14:8], 8'h00};
            bus(1'b1, `TOIS_OFF_CTRL2, ctrl_m | 32'h0000_00FF);
            bus(1'b0, `TOIS_OFF_CTRL2, 32'h0000_0000);
            chk("ctrl2_read", rd, ctrl_m);
            idle_chk();
        end
        $display("test idle_walk done");
        bus(1'b1, 4'h2, 32'h0000_7F00);
        chk("bad_bresp", 32'(rs), 32'(`TOIS_RESP_SLVERR));
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk("bad_rresp", 32'(rs), 32'(`TOIS_RESP_SLVERR));
        bus(1'b0, `TOIS_OFF_CTRL2, 32'h0000_0000);
        chk("ctrl2_kept", rd, ctrl_m);
        chk("ctrl2_rresp", 32'(rs), 32'(`TOIS_RESP_OKAY));
        $display("test unmapped done");
        bus(1'b1, `TOIS_OFF_OUTEN, 32'h0000_0301);
        repeat (8) @(posedge clock);
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            rd = {25'h0, run_levels};
            #1 chk("run_follow", 32'(out_pins), rd);
        end
        bus(1'b1, `TOIS_OFF_OUTEN, 32'h0000_0300);
        idle_chk();
        $display("test enable_cycle done");
        for (lvl = 1; lvl < 4; lvl++) begin
            do_reset();
            ctrl_m = 32'h0000_5500;
            bus(1'b1, `TOIS_OFF_CTRL2, ctrl_m);
            bus(1'b1, `TOIS_OFF_LOCK, 32'(lvl));
            bus(1'b1, `TOIS_OFF_CTRL2, 32'h0000_2A00);
            chk("lock_resp", 32'(rs), 32'(`TOIS_RESP_OKAY));
            bus(1'b0, `TOIS_OFF_CTRL2, 32'h0000_0000);
            chk("lock_ctrl2", rd, ctrl_m);
            idle_chk();
            bus(1'b0, `TOIS_OFF_STATUS, 32'h0000_0000);
            chk("status", rd, 32'h0000_7F55);
        end
        $display("test lock_levels done");
        give_verdict();
    end
endmodule // tois_top_tb
`default_nettype wire
